// ==== rtl/i2c_link_pkg.sv ====
/*
 * Shared constants and types for the I2C target port and its controller.
 * Assumes a 125 MHz system clock on the controller and an oversampling link clock
 * on the target.
 */
package i2c_link_pkg;

	// Bus addressing
	localparam int ADDR_W = 7;
	localparam int BYTE_W = 8;
	localparam logic [6:0] TARGET_ADDR = 7'h7F;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;

	// Nine clock pulses per byte: eight data bits, then the acknowledge
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [7:0] MEM_RESET = 8'h00;

	// Bus timing, in ns as specified, and in system clock cycles
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_LOW_NS = 1300;
	localparam int T_HIGH_NS = 600;
	localparam int T_SU_STA_NS = 600;
	localparam int T_HD_STA_NS = 600;
	localparam int T_SU_STO_NS = 600;
	localparam int T_BUF_NS = 1300;
	localparam logic [7:0] LOW_CYC = 8'((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] HIGH_CYC = 8'((T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] SU_STA_CYC = 8'((T_SU_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] HD_STA_CYC = 8'((T_HD_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] SU_STO_CYC = 8'((T_SU_STO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] BUF_CYC = 8'((T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// SDA is moved halfway through SCL low, well clear of both edges
	localparam logic [7:0] LOW_MID_CYC = 8'(LOW_CYC / 2);

	typedef enum logic [1:0] {
		BYTE_ADDR = 2'h0,
		BYTE_REG = 2'h1,
		BYTE_DATA = 2'h2
	} byte_kind_t;

	typedef enum logic [4:0] {
		DEV_IDLE = 5'h01,
		DEV_RX = 5'h02,
		DEV_ACK = 5'h04,
		DEV_TX = 5'h08,
		DEV_MACK = 5'h10
	} dev_state_t;

	typedef enum logic [8:0] {
		CTL_IDLE = 9'h001,
		CTL_STA_SU = 9'h002,
		CTL_STA_HD = 9'h004,
		CTL_LO = 9'h008,
		CTL_HI = 9'h010,
		CTL_RS_LO = 9'h020,
		CTL_STO_LO = 9'h040,
		CTL_STO_SU = 9'h080,
		CTL_STO_BUF = 9'h100
	} ctl_state_t;

endpackage : i2c_link_pkg

// ==== rtl/i2c_link_if.sv ====
/*
 * The two open-drain bus wires between controller and target.
 * Assumes the pull-ups: a wire reads high unless some enabled driver pulls it low.
 */
`timescale 1ns/100ps
interface i2c_link_if;
	logic scl_o_ctl;
	logic scl_oe_ctl;
	logic sda_o_ctl;
	logic sda_oe_ctl;
	logic sda_o_dev;
	logic sda_oe_dev;
	logic scl;
	logic sda;

	// Wired-AND with pull-up
	assign scl = scl_oe_ctl ? scl_o_ctl : 1'b1;
	assign sda = (sda_oe_ctl ? sda_o_ctl : 1'b1) & (sda_oe_dev ? sda_o_dev : 1'b1);

	modport ctl (
		output scl_o_ctl,
		output scl_oe_ctl,
		output sda_o_ctl,
		output sda_oe_ctl,
		input scl,
		input sda
	);

	modport dev (
		output sda_o_dev,
		output sda_oe_dev,
		input scl,
		input sda
	);
endinterface : i2c_link_if

// ==== rtl/i2c_bus_controller.sv ====
/*
 * Bus controller end: turns one write or read command into a full bus transfer.
 * Assumes a 125 MHz clock and a target that never stretches SCL.
 */
`timescale 1ns/100ps
module i2c_bus_controller (
	// System
	input wire logic clock,
	input wire logic sys_rst,
	// Bus
	i2c_link_if.ctl bus,
	// Command
	input wire logic cmd_valid,
	input wire logic cmd_read,
	input wire logic [7:0] cmd_reg,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	// Response
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack
);
	i2c_link_pkg::ctl_state_t state_ff;
	logic [7:0] tmr_ff;
	logic [3:0] bit_ff;
	logic [1:0] step_ff;
	logic [7:0] byte_ff;
	logic [7:0] rx_ff;
	logic read_ff;
	logic [7:0] reg_ff;
	logic [7:0] data_ff;
	logic nack_ff;
	logic scl_oe_ff;
	logic sda_oe_ff;
	logic sda_m_ff;
	logic sda_s_ff;
	logic rx_step;
	logic last_step;

	// Byte sent in each step of a transfer
	function automatic logic [7:0] step_byte(input logic [1:0] step, input logic rd,
		input logic [7:0] rg, input logic [7:0] dt);
		logic [7:0] b;
		b = {i2c_link_pkg::TARGET_ADDR, i2c_link_pkg::DIR_WRITE};
		if (step == 2'h1)
			b = rg;
		else if (step == 2'h2)
			b = rd ? {i2c_link_pkg::TARGET_ADDR, i2c_link_pkg::DIR_READ} : dt;
		return b;
	endfunction : step_byte

	assign rx_step = read_ff && (step_ff == 2'h3);
	assign last_step = read_ff ? (step_ff == 2'h3) : (step_ff == 2'h2);

	// Pin input, two stages before use
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sda_m_ff <= 1'b1;
			sda_s_ff <= 1'b1;
		end
		else
		begin
			sda_m_ff <= bus.sda;
			sda_s_ff <= sda_m_ff;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state_ff <= i2c_link_pkg::CTL_IDLE;
			tmr_ff <= '0;
			bit_ff <= '0;
			step_ff <= '0;
			byte_ff <= '0;
			rx_ff <= '0;
			read_ff <= 1'b0;
			reg_ff <= '0;
			data_ff <= '0;
			nack_ff <= 1'b0;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			rsp_nack <= 1'b0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			if (tmr_ff != 8'h00)
				tmr_ff <= tmr_ff - 8'h01;
			unique case (state_ff)
			i2c_link_pkg::CTL_IDLE:
			begin
				cmd_ready <= 1'b1;
				if (cmd_valid && cmd_ready)
				begin
					cmd_ready <= 1'b0;
					read_ff <= cmd_read;
					reg_ff <= cmd_reg;
					data_ff <= cmd_data;
					nack_ff <= 1'b0;
					step_ff <= '0;
					byte_ff <= {i2c_link_pkg::TARGET_ADDR, i2c_link_pkg::DIR_WRITE};
					tmr_ff <= i2c_link_pkg::SU_STA_CYC;
					state_ff <= i2c_link_pkg::CTL_STA_SU;
				end
			end
			i2c_link_pkg::CTL_STA_SU:
				if (tmr_ff == 8'h00)
				begin
					sda_oe_ff <= 1'b1;
					tmr_ff <= i2c_link_pkg::HD_STA_CYC;
					state_ff <= i2c_link_pkg::CTL_STA_HD;
				end
			i2c_link_pkg::CTL_STA_HD:
				if (tmr_ff == 8'h00)
				begin
					scl_oe_ff <= 1'b1;
					bit_ff <= '0;
					tmr_ff <= i2c_link_pkg::LOW_CYC;
					state_ff <= i2c_link_pkg::CTL_LO;
				end
			i2c_link_pkg::CTL_LO:
			begin
				// Data moves only while SCL is low; released for ack and read bits
				if (tmr_ff == i2c_link_pkg::LOW_MID_CYC)
					sda_oe_ff <= !rx_step && (bit_ff != i2c_link_pkg::BIT_ACK) && !byte_ff[7];
				if (tmr_ff == 8'h00)
				begin
					scl_oe_ff <= 1'b0;
					tmr_ff <= i2c_link_pkg::HIGH_CYC;
					state_ff <= i2c_link_pkg::CTL_HI;
				end
			end
			i2c_link_pkg::CTL_HI:
				if (tmr_ff == 8'h00)
				begin
					scl_oe_ff <= 1'b1;
					tmr_ff <= i2c_link_pkg::LOW_CYC;
					if (bit_ff != i2c_link_pkg::BIT_ACK)
					begin
						rx_ff <= {rx_ff[6:0], sda_s_ff};
						byte_ff <= {byte_ff[6:0], 1'b0};
						bit_ff <= bit_ff + 4'h1;
						state_ff <= i2c_link_pkg::CTL_LO;
					end
					else if ((!rx_step && sda_s_ff) || last_step)
					begin
						nack_ff <= !rx_step && sda_s_ff;
						state_ff <= i2c_link_pkg::CTL_STO_LO;
					end
					else if (read_ff && step_ff == 2'h1)
						state_ff <= i2c_link_pkg::CTL_RS_LO;
					else
					begin
						step_ff <= step_ff + 2'h1;
						byte_ff <= step_byte(step_ff + 2'h1, read_ff, reg_ff, data_ff);
						bit_ff <= '0;
						state_ff <= i2c_link_pkg::CTL_LO;
					end
				end
			i2c_link_pkg::CTL_RS_LO:
				if (tmr_ff == 8'h00)
				begin
					scl_oe_ff <= 1'b0;
					step_ff <= 2'h2;
					byte_ff <= step_byte(2'h2, read_ff, reg_ff, data_ff);
					tmr_ff <= i2c_link_pkg::SU_STA_CYC;
					state_ff <= i2c_link_pkg::CTL_STA_SU;
				end
			i2c_link_pkg::CTL_STO_LO:
			begin
				if (tmr_ff == i2c_link_pkg::LOW_MID_CYC)
					sda_oe_ff <= 1'b1;
				if (tmr_ff == 8'h00)
				begin
					scl_oe_ff <= 1'b0;
					tmr_ff <= i2c_link_pkg::SU_STO_CYC;
					state_ff <= i2c_link_pkg::CTL_STO_SU;
				end
			end
			i2c_link_pkg::CTL_STO_SU:
				if (tmr_ff == 8'h00)
				begin
					sda_oe_ff <= 1'b0;
					tmr_ff <= i2c_link_pkg::BUF_CYC;
					state_ff <= i2c_link_pkg::CTL_STO_BUF;
				end
			i2c_link_pkg::CTL_STO_BUF:
				if (tmr_ff == 8'h00)
				begin
					rsp_valid <= 1'b1;
					rsp_data <= rx_ff;
					rsp_nack <= nack_ff;
					state_ff <= i2c_link_pkg::CTL_IDLE;
				end
			endcase
		end
	end

	// Open drain: only ever pulls low
	assign bus.scl_o_ctl = 1'b0;
	assign bus.sda_o_ctl = 1'b0;
	assign bus.scl_oe_ctl = scl_oe_ff;
	assign bus.sda_oe_ctl = sda_oe_ff;

endmodule : i2c_bus_controller

// ==== rtl/sensor_i2c_target_port.sv ====
/*
 * Target end of the sensor's two-wire port, with a 256-byte register space.
 * Assumes link_clk oversamples SCL and SDA (several edges per SCL phase) and that
 * the controller owns SCL; register writes are reported in the clock domain.
 */
`timescale 1ns/100ps
module sensor_i2c_target_port (
	// System
	input wire logic clock,
	input wire logic sys_rst,
	// Link
	input wire logic link_clk,
	i2c_link_if.dev bus,
	// Register write report
	output logic wr_valid,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data
);
	logic rst_m_ff;
	logic link_rst_ff;
	logic scl_m_ff;
	logic scl_s_ff;
	logic scl_d_ff;
	logic sda_m_ff;
	logic sda_s_ff;
	logic sda_d_ff;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	i2c_link_pkg::dev_state_t state_ff;
	i2c_link_pkg::byte_kind_t kind_ff;
	logic [3:0] cnt_ff;
	logic [7:0] shreg_ff;
	logic [7:0] tx_sh_ff;
	logic rw_ff;
	logic [7:0] ptr_ff;
	logic sda_oe_ff;
	logic wr_en;
	logic [7:0] mem [0:255];
	logic [7:0] ev_addr_ff;
	logic [7:0] ev_data_ff;
	logic ev_tgl_ff;
	logic tgl_m_ff;
	logic tgl_s_ff;
	logic tgl_d_ff;

	// Reset into the link domain
	always_ff @(posedge link_clk)
	begin
		rst_m_ff <= sys_rst;
		link_rst_ff <= rst_m_ff;
	end

	// Bus wires, two stages plus a delayed copy for edges
	always_ff @(posedge link_clk)
	begin
		if (link_rst_ff)
		begin
			scl_m_ff <= 1'b1;
			scl_s_ff <= 1'b1;
			scl_d_ff <= 1'b1;
			sda_m_ff <= 1'b1;
			sda_s_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end
		else
		begin
			scl_m_ff <= bus.scl;
			scl_s_ff <= scl_m_ff;
			scl_d_ff <= scl_s_ff;
			sda_m_ff <= bus.sda;
			sda_s_ff <= sda_m_ff;
			sda_d_ff <= sda_s_ff;
		end
	end

	assign scl_rise = scl_s_ff && !scl_d_ff;
	assign scl_fall = !scl_s_ff && scl_d_ff;
	// SDA moving while SCL is high is a start or a stop, never data
	assign start_det = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
	assign stop_det = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;

	assign wr_en = (state_ff == i2c_link_pkg::DEV_RX) && scl_fall
		&& (cnt_ff == i2c_link_pkg::BIT_ACK) && (kind_ff == i2c_link_pkg::BYTE_DATA);

	always_ff @(posedge link_clk)
	begin
		if (link_rst_ff)
		begin
			state_ff <= i2c_link_pkg::DEV_IDLE;
			kind_ff <= i2c_link_pkg::BYTE_ADDR;
			cnt_ff <= '0;
			shreg_ff <= '0;
			tx_sh_ff <= '0;
			rw_ff <= 1'b0;
			ptr_ff <= '0;
			sda_oe_ff <= 1'b0;
		end
		else if (start_det)
		begin
			// Also a repeated start: the register pointer is kept
			state_ff <= i2c_link_pkg::DEV_RX;
			kind_ff <= i2c_link_pkg::BYTE_ADDR;
			cnt_ff <= '0;
			sda_oe_ff <= 1'b0;
		end
		else if (stop_det)
		begin
			state_ff <= i2c_link_pkg::DEV_IDLE;
			sda_oe_ff <= 1'b0;
		end
		else
		begin
			unique case (state_ff)
			i2c_link_pkg::DEV_IDLE:
				sda_oe_ff <= 1'b0;
			i2c_link_pkg::DEV_RX:
				if (scl_rise && cnt_ff != i2c_link_pkg::BIT_ACK)
				begin
					shreg_ff <= {shreg_ff[6:0], sda_s_ff};
					cnt_ff <= cnt_ff + 4'h1;
				end
				else if (scl_fall && cnt_ff == i2c_link_pkg::BIT_ACK)
				begin
					if (kind_ff == i2c_link_pkg::BYTE_ADDR
						&& shreg_ff[7:1] != i2c_link_pkg::TARGET_ADDR)
						state_ff <= i2c_link_pkg::DEV_IDLE;
					else
					begin
						// Pull low for the whole ninth pulse
						state_ff <= i2c_link_pkg::DEV_ACK;
						sda_oe_ff <= 1'b1;
						if (kind_ff == i2c_link_pkg::BYTE_ADDR)
							rw_ff <= shreg_ff[0];
						if (kind_ff == i2c_link_pkg::BYTE_REG)
							ptr_ff <= shreg_ff;
						if (kind_ff == i2c_link_pkg::BYTE_DATA)
							ptr_ff <= ptr_ff + 8'h01;
					end
				end
			i2c_link_pkg::DEV_ACK:
				if (scl_fall)
				begin
					cnt_ff <= '0;
					if (kind_ff == i2c_link_pkg::BYTE_ADDR && rw_ff == i2c_link_pkg::DIR_READ)
					begin
						state_ff <= i2c_link_pkg::DEV_TX;
						sda_oe_ff <= !mem[ptr_ff][7];
						tx_sh_ff <= {mem[ptr_ff][6:0], 1'b0};
						cnt_ff <= 4'h1;
					end
					else
					begin
						state_ff <= i2c_link_pkg::DEV_RX;
						sda_oe_ff <= 1'b0;
						if (kind_ff == i2c_link_pkg::BYTE_ADDR)
							kind_ff <= i2c_link_pkg::BYTE_REG;
						else
							kind_ff <= i2c_link_pkg::BYTE_DATA;
					end
				end
			i2c_link_pkg::DEV_TX:
				if (scl_fall)
				begin
					if (cnt_ff == i2c_link_pkg::BIT_ACK)
					begin
						sda_oe_ff <= 1'b0;
						state_ff <= i2c_link_pkg::DEV_MACK;
					end
					else
					begin
						sda_oe_ff <= !tx_sh_ff[7];
						tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
						cnt_ff <= cnt_ff + 4'h1;
					end
				end
			i2c_link_pkg::DEV_MACK:
				if (scl_rise)
				begin
					// A not-acknowledge ends the read; an ack asks for the next byte
					if (sda_s_ff)
						state_ff <= i2c_link_pkg::DEV_IDLE;
					else
					begin
						ptr_ff <= ptr_ff + 8'h01;
						state_ff <= i2c_link_pkg::DEV_ACK;
					end
				end
			endcase
		end
	end

	// Register space; stays on the link clock so reads need no crossing
	always_ff @(posedge link_clk)
	begin
		if (link_rst_ff)
		begin
			for (int i = 0; i < 256; i++)
				mem[i] <= i2c_link_pkg::MEM_RESET;
		end
		else if (wr_en)
			mem[ptr_ff] <= shreg_ff;
	end

	// Write event: data held stable, toggle flips once per write
	always_ff @(posedge link_clk)
	begin
		if (link_rst_ff)
		begin
			ev_addr_ff <= '0;
			ev_data_ff <= '0;
			ev_tgl_ff <= 1'b0;
		end
		else if (wr_en)
		begin
			ev_addr_ff <= ptr_ff;
			ev_data_ff <= shreg_ff;
			ev_tgl_ff <= !ev_tgl_ff;
		end
	end

	// Toggle into the system clock; address and data have settled long before
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			tgl_m_ff <= 1'b0;
			tgl_s_ff <= 1'b0;
			tgl_d_ff <= 1'b0;
			wr_valid <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
		end
		else
		begin
			tgl_m_ff <= ev_tgl_ff;
			tgl_s_ff <= tgl_m_ff;
			tgl_d_ff <= tgl_s_ff;
			wr_valid <= tgl_s_ff ^ tgl_d_ff;
			if (tgl_s_ff ^ tgl_d_ff)
			begin
				wr_addr <= ev_addr_ff;
				wr_data <= ev_data_ff;
			end
		end
	end

	// Open drain: only ever pulls low
	assign bus.sda_o_dev = 1'b0;
	assign bus.sda_oe_dev = sda_oe_ff;

endmodule : sensor_i2c_target_port

// ==== verif/sensor_i2c_target_port_chk.sv ====
/*
 * Checker for the two-wire link between the bus controller and the target port.
 * Assumes it watches the interface that joins both design ends, sampled on clock.
 */
`timescale 1ns/100ps
module sensor_i2c_target_port_chk (
	// System
	input wire logic clock,
	input wire logic sys_rst,
	// Link
	input wire logic scl_o_ctl,
	input wire logic scl_oe_ctl,
	input wire logic sda_o_ctl,
	input wire logic sda_oe_ctl,
	input wire logic sda_o_dev,
	input wire logic sda_oe_dev,
	input wire logic scl,
	input wire logic sda
);
	logic scl_ff;
	logic sda_ff;
	logic first_ff;
	logic [3:0] pulse_ff;
	logic start_seen;
	logic scl_rise;

	assign start_seen = scl && scl_ff && sda_ff && !sda;
	assign scl_rise = scl && !scl_ff;

	always_ff @(posedge clock)
	begin
		scl_ff <= sys_rst ? 1'h1 : scl;
		sda_ff <= sys_rst ? 1'h1 : sda;
	end

	// Pulse index within the current byte; the first byte after a start is the address
	always_ff @(posedge clock)
	begin
		if (sys_rst || start_seen)
			pulse_ff <= 4'h0;
		else if (scl_rise)
			pulse_ff <= (pulse_ff == 4'h8) ? 4'h0 : pulse_ff + 4'h1;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			first_ff <= 1'h0;
		else if (start_seen)
			first_ff <= 1'h1;
		else if (scl_rise && pulse_ff == 4'h8)
			first_ff <= 1'h0;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	ctl_pull_low_a: assert property (!scl_o_ctl && !sda_o_ctl)
		else $error("controller drives a line high");
	dev_pull_low_a: assert property (!sda_o_dev)
		else $error("target drives SDA high");
	dev_sda_hold_a: assert property ($changed(sda_oe_dev) |-> !scl && !$past(scl))
		else $error("target moved SDA while SCL high");
	scl_high_a: assert property ($rose(scl) |-> scl [*8])
		else $error("SCL high phase too short");
	start_hold_a: assert property ($rose(sda_oe_ctl) && scl |-> (scl && !sda) [*8])
		else $error("start not held with SCL high");
	stop_release_a: assert property ($fell(sda_oe_ctl) && scl |-> (sda && !sda_oe_dev) [*8])
		else $error("stop left SDA held low");
	addr_bits_a: assert property (scl_rise && first_ff && pulse_ff < 4'h7 |-> sda)
		else $error("address bit differs from target address");
	addr_ack_a: assert property (scl_rise && first_ff && pulse_ff == 4'h8 |-> (sda_oe_dev && !sda) [*8])
		else $error("address not acknowledged for the ninth pulse");

	cover property (start_seen);
	cover property (scl_rise && pulse_ff == 4'h8 && sda);
	cover property ($fell(sda_oe_ctl) && scl);
endmodule : sensor_i2c_target_port_chk

// ==== verif/sensor_i2c_target_port_test.sv ====
/*
 * Testbench: controller and target face each other on one link; a second target on
 * its own link is driven by a controller bit-banged by the bench to reach foreign addresses.
 * Assumes the design package, the link interface and both design ends are compiled first.
 */
`timescale 1ns/100ps
module sensor_i2c_target_port_test;
	localparam int LIMIT = 80000;
	logic clock = 1'h0;
	logic link_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic cmd_valid = 1'h0;
	logic cmd_read = 1'h0;
	logic [7:0] cmd_reg = 8'h00;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_ready, rsp_valid, rsp_nack, wr_valid, wr_valid_b;
	logic [7:0] rsp_data, wr_addr, wr_data, wr_addr_b, wr_data_b;
	logic [7:0] last_addr, last_data, last_addr_b, last_data_b;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	int wr_seen = 0;
	int wr_seen_b = 0;
	logic op_rd [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
	logic [7:0] op_reg [5] = '{8'h10, 8'hFF, 8'h10, 8'hFF, 8'h00};
	logic [7:0] op_dat [5] = '{8'hAB, 8'h5A, 8'hAB, 8'h5A, 8'h00};

	i2c_link_if link_a();
	i2c_link_if link_b();

	i2c_bus_controller i_i2c_bus_controller (.clock, .sys_rst, .bus(link_a), .cmd_valid,
		.cmd_read, .cmd_reg, .cmd_data, .cmd_ready, .rsp_valid, .rsp_data, .rsp_nack);
	sensor_i2c_target_port i_sensor_i2c_target_port (.clock, .sys_rst, .link_clk,
		.bus(link_a), .wr_valid, .wr_addr, .wr_data);
	sensor_i2c_target_port i_sensor_i2c_target_port_b (.clock, .sys_rst, .link_clk,
		.bus(link_b), .wr_valid(wr_valid_b), .wr_addr(wr_addr_b), .wr_data(wr_data_b));
	sensor_i2c_target_port_chk i_sensor_i2c_target_port_chk (.clock, .sys_rst,
		.scl_o_ctl(link_a.scl_o_ctl), .scl_oe_ctl(link_a.scl_oe_ctl),
		.sda_o_ctl(link_a.sda_o_ctl), .sda_oe_ctl(link_a.sda_oe_ctl),
		.sda_o_dev(link_a.sda_o_dev), .sda_oe_dev(link_a.sda_oe_dev),
		.scl(link_a.scl), .sda(link_a.sda));

	always #4 clock = ~clock;
	// Offset start keeps link edges off the system clock edges
	initial #1.5 forever #24 link_clk = ~link_clk;

	always @(negedge clock)
	begin
		if (wr_valid === 1'h1)
		begin
			wr_seen++;
			last_addr = wr_addr;
			last_data = wr_data;
		end
		if (wr_valid_b === 1'h1)
		begin
			wr_seen_b++;
			last_addr_b = wr_addr_b;
			last_data_b = wr_data_b;
		end
	end

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			failures++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("Checked %0d, failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic run_cmd(input logic rd, input logic [7:0] rg, input logic [7:0] dt);
		@(negedge clock);
		while (cmd_ready !== 1'h1)
			@(negedge clock);
		@(posedge clock);
		cmd_read <= rd;
		cmd_reg <= rg;
		cmd_data <= dt;
		cmd_valid <= 1'h1;
		@(posedge clock);
		cmd_valid <= 1'h0;
		do
			@(negedge clock);
		while (rsp_valid !== 1'h1);
	endtask : run_cmd

	task automatic bb_wait(input int n);
		repeat (n) @(posedge clock);
	endtask : bb_wait

	// SDA moves mid-low; SCL high lasts about five link clocks so the target sees it
	task automatic bb_bit(input logic b, output logic seen);
		link_b.sda_oe_ctl <= !b;
		bb_wait(20);
		link_b.scl_oe_ctl <= 1'h0;
		bb_wait(15);
		@(negedge clock);
		seen = link_b.sda;
		bb_wait(15);
		link_b.scl_oe_ctl <= 1'h1;
		bb_wait(20);
	endtask : bb_bit

	task automatic bb_byte(input logic [7:0] v, output logic ackd);
		logic s;
		for (int i = 7; i >= 0; i--)
			bb_bit(v[i], s);
		bb_bit(1'h1, s);
		ackd = !s;
	endtask : bb_byte

	task automatic bb_frame(input logic [6:0] ad, input logic [7:0] rg, input logic [7:0] dt,
		output logic [2:0] acks);
		link_b.sda_oe_ctl <= 1'h1;
		bb_wait(20);
		link_b.scl_oe_ctl <= 1'h1;
		bb_wait(20);
		bb_byte({ad, i2c_link_pkg::DIR_WRITE}, acks[2]);
		bb_byte(rg, acks[1]);
		bb_byte(dt, acks[0]);
		link_b.sda_oe_ctl <= 1'h1;
		bb_wait(20);
		link_b.scl_oe_ctl <= 1'h0;
		bb_wait(20);
		link_b.sda_oe_ctl <= 1'h0;
		bb_wait(40);
	endtask : bb_frame

	initial
	begin
		int n;
		logic [2:0] acks;
		link_b.scl_o_ctl = 1'h0;
		link_b.scl_oe_ctl = 1'h0;
		link_b.sda_o_ctl = 1'h0;
		link_b.sda_oe_ctl = 1'h0;
		// Long enough for the target's link-side reset synchroniser
		repeat (24) @(posedge clock);
		sys_rst <= 1'h0;
		for (int i = 0; i < 5; i++)
		begin
			n = wr_seen;
			run_cmd(op_rd[i], op_reg[i], op_dat[i]);
			check("nack", {7'h00, rsp_nack}, 8'h00);
			check("reports", 8'(wr_seen - n), {7'h00, !op_rd[i]});
			if (op_rd[i])
				check("read data", rsp_data, op_dat[i]);
			else
			begin
				check("report addr", last_addr, op_reg[i]);
				check("report data", last_data, op_dat[i]);
			end
			$display("Test op %0d done", i);
		end
		bb_frame(7'h7E, 8'h22, 8'h55, acks);
		check("foreign acks", {5'h00, acks}, 8'h00);
		check("foreign reports", 8'(wr_seen_b), 8'h00);
		bb_frame(i2c_link_pkg::TARGET_ADDR, 8'h33, 8'hC6, acks);
		check("own acks", {5'h00, acks}, 8'h07);
		check("own addr", last_addr_b, 8'h33);
		check("own data", last_data_b, 8'hC6);
		$display("Test foreign and own address done");
		give_verdict();
	end
endmodule : sensor_i2c_target_port_test
